// *** psw_pkg.sv ***
// Package: shared constants and types for the protection switch-over machines
// What this block does
// - Standard command sends, starts timer, enters initiated
// - Standard command carries logical and standby channel
// - Access side idle takes command, indicates, initiated
// - Management accept sends acknowledge, access returns idle
// - Acknowledge indicates, stops timer, exchange returns idle
// - Request message ignored while exchange initiated
// - Management refusal sends reject with cause
// - Reject in standard run stops standard timer
// - Reject in forced run stops forced timer
// - Unexpected management primitive is silently discarded
// - First standard expiry resends command, restarts timer
// - Second standard expiry raises error, returns idle
// - Acknowledge in idle still indicates, stays idle
// - Reject in idle still indicates, stays idle
// - Standard expiry outside initiated does nothing
// - Forced command sends, starts forced timer, initiated
// - Forced command names channel; active target pre-empted
// - Forced command allowed only for protection group two
// - Access idle takes forced command, indicates operator
// - Forced command never rejected for occupied target
// - Forced expiries resend once, then error, idle
// - Forced expiry outside initiated does nothing
package psw_pkg;
   // ------------------------------------------------------------
   // Widths and timing
   // ------------------------------------------------------------
   localparam int CH_W           = 16;
   localparam int CAUSE_W        = 8;
   localparam int GROUP_W        = 2;
   localparam int TMR_W          = 12;
   localparam logic [GROUP_W-1:0] OS_GROUP = 2'h2;
   localparam int STD_RETRY_CYC  = 1000;
   localparam int OS_RETRY_CYC   = 1000;
   // Cause forbidden in answer to a forced command
   localparam logic [CAUSE_W-1:0] CAUSE_TARGET_OCCUPIED = 8'h05;
   localparam logic [CAUSE_W-1:0] CAUSE_NO_RESOURCE     = 8'h01;

   // ------------------------------------------------------------
   // Message and state types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PSW_MSG_NONE  = 3'h0,
      PSW_MSG_COM   = 3'h1,
      PSW_MSG_OSCOM = 3'h2,
      PSW_MSG_ACK   = 3'h3,
      PSW_MSG_REJ   = 3'h4,
      PSW_MSG_REQ   = 3'h5
   } psw_msg_t;

   typedef enum logic [2:0] {
      LE_IDLE_STATE              = 3'b001,
      LE_SWITCH_INITIATED_STATE  = 3'b010,
      LE_AN_REQUESTED_STATE      = 3'b100
   } psw_le_state_t;

   typedef enum logic [1:0] {
      AN_IDLE_STATE         = 2'b01,
      AN_LE_INITIATED_STATE = 2'b10
   } psw_an_state_t;
endpackage

// *** psw_link_if.sv ***
// Interface: message link between exchange and access protection entities
`timescale 1ns/10ps
interface psw_link_if;
   import psw_pkg::*;
   // Exchange to access
   logic                 le_msg_valid;
   psw_msg_t             le_msg_type;
   logic [CH_W-1:0]      le_msg_lchan;
   logic [CH_W-1:0]      le_msg_target;
   // Access to exchange
   logic                 an_msg_valid;
   psw_msg_t             an_msg_type;
   logic [CAUSE_W-1:0]   an_msg_cause;

   modport le (output le_msg_valid, le_msg_type, le_msg_lchan, le_msg_target,
               input an_msg_valid, an_msg_type, an_msg_cause);
   modport an (input le_msg_valid, le_msg_type, le_msg_lchan, le_msg_target,
               output an_msg_valid, an_msg_type, an_msg_cause);
endinterface

// *** psw_le_end.sv ***
// Module: exchange-side switch-over machine with two retry timers
`timescale 1ns/10ps
module psw_le_end #(
   parameter int STD_CYC = psw_pkg::STD_RETRY_CYC,
   parameter int OS_CYC  = psw_pkg::OS_RETRY_CYC
) (
   input  wire logic                          core_clk,
   input  wire logic                          rst_b,
   psw_link_if.le                             link,
   input  wire logic                          mgmt_std_com,
   input  wire logic                          mgmt_os_com,
   input  wire logic [psw_pkg::GROUP_W-1:0]   mgmt_group,
   input  wire logic [psw_pkg::CH_W-1:0]      mgmt_lchan,
   input  wire logic [psw_pkg::CH_W-1:0]      mgmt_target,
   input  wire logic                          mgmt_an_req,
   output logic                               ind_ack,
   output logic                               ind_reject,
   output logic [psw_pkg::CAUSE_W-1:0]        ind_cause,
   output logic                               ind_error,
   output logic                               ind_an_req,
   output logic [1:0]                         le_state
);
   import psw_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      psw_le_state_t       st;
      logic                os_run;
      logic                tmr_on;
      logic [TMR_W-1:0]    tmr;
      logic                expired_once;
      logic                tx_valid;
      psw_msg_t            tx_type;
      logic [CH_W-1:0]     lchan;
      logic [CH_W-1:0]     target;
      logic                ack;
      logic                rej;
      logic [CAUSE_W-1:0]  cause;
      logic                err;
      logic                anreq;
   } psw_le_reg_t;

   localparam logic [TMR_W-1:0] STD_LOAD = TMR_W'(STD_CYC - 1);
   localparam logic [TMR_W-1:0] OS_LOAD  = TMR_W'(OS_CYC - 1);

   psw_le_reg_t r_q;
   psw_le_reg_t r_d;
   logic        expire;
   logic        in_rx;
   logic        in_idle;
   logic        rx_ack;
   logic        rx_rej;
   logic        rx_req;

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   // A received message of the wanted type, seen only while valid
   function automatic logic rx_is(input logic     valid,
                                  input psw_msg_t got,
                                  input psw_msg_t want);
      return valid && (got == want);
   endfunction

   // Outward state code: 0 idle, 1 switch-initiated, 2 far-side requested
   function automatic logic [1:0] state_code(input psw_le_state_t st);
      logic [1:0] code;
      case (st)
         LE_SWITCH_INITIATED_STATE: begin
            code = 2'h1;
         end
         LE_AN_REQUESTED_STATE: begin
            code = 2'h2;
         end
         default: begin
            code = 2'h0;
         end
      endcase
      return code;
   endfunction

   // ------------------------------------------------------------
   // Timer and received messages
   // ------------------------------------------------------------
   // One countdown serves both retry timers: only one command is ever
   // outstanding, so the timer of the other kind is never armed
   // Expiry is one pulse when the running countdown reaches zero
   assign expire  = r_q.tmr_on && (r_q.tmr == '0);
   assign in_rx   = link.an_msg_valid;
   assign in_idle = (r_q.st == LE_IDLE_STATE);
   assign rx_ack  = rx_is(in_rx, link.an_msg_type, PSW_MSG_ACK);
   assign rx_rej  = rx_is(in_rx, link.an_msg_type, PSW_MSG_REJ);
   assign rx_req  = rx_is(in_rx, link.an_msg_type, PSW_MSG_REQ);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      r_d          = r_q;
      r_d.tx_valid = 1'b0;
      r_d.ack      = 1'b0;
      r_d.rej      = 1'b0;
      r_d.err      = 1'b0;
      r_d.anreq    = 1'b0;
      if (r_q.tmr_on && !expire) begin
         r_d.tmr = r_q.tmr - 1'b1;
      end
      // A timer expiry in any other state is dropped
      if (expire) begin
         r_d.tmr_on = 1'b0;
      end
      case (r_q.st)
         LE_IDLE_STATE, LE_AN_REQUESTED_STATE: begin
            if (mgmt_std_com) begin
               // Send command with logical and standby channel
               r_d.tx_valid     = 1'b1;
               r_d.tx_type      = PSW_MSG_COM;
               r_d.lchan        = mgmt_lchan;
               r_d.target       = mgmt_target;
               r_d.os_run       = 1'b0;
               r_d.tmr_on       = 1'b1;
               r_d.tmr          = STD_LOAD;
               r_d.expired_once = 1'b0;
               r_d.st           = LE_SWITCH_INITIATED_STATE;
            end else if (mgmt_os_com && mgmt_group == OS_GROUP) begin
               // Forced command only for group two; others discarded
               r_d.tx_valid     = 1'b1;
               r_d.tx_type      = PSW_MSG_OSCOM;
               r_d.lchan        = mgmt_lchan;
               r_d.target       = mgmt_target;
               r_d.os_run       = 1'b1;
               r_d.tmr_on       = 1'b1;
               r_d.tmr          = OS_LOAD;
               r_d.expired_once = 1'b0;
               r_d.st           = LE_SWITCH_INITIATED_STATE;
            end else if (rx_ack && in_idle) begin
               // Late answers in idle are still passed up to management
               r_d.ack = 1'b1;
            end else if (rx_rej && in_idle) begin
               r_d.rej   = 1'b1;
               r_d.cause = link.an_msg_cause;
            end else if (rx_req && in_idle) begin
               // Request from the far side parks the machine awaiting management
               r_d.anreq = 1'b1;
               r_d.st    = LE_AN_REQUESTED_STATE;
            end else if (mgmt_an_req && !in_idle) begin
               r_d.st = LE_IDLE_STATE;
            end
         end
         LE_SWITCH_INITIATED_STATE: begin
            // Management commands here are unexpected and discarded
            // An answer outranks an expiry in the same cycle, so it is never lost
            if (rx_ack) begin
               r_d.ack    = 1'b1;
               r_d.tmr_on = 1'b0;
               r_d.st     = LE_IDLE_STATE;
            end else if (rx_rej) begin
               // Stops whichever timer runs, standard or forced
               r_d.rej    = 1'b1;
               r_d.cause  = link.an_msg_cause;
               r_d.tmr_on = 1'b0;
               r_d.st     = LE_IDLE_STATE;
            end else if (expire && !r_q.expired_once) begin
               // Resend same command and restart its timer
               r_d.tx_valid     = 1'b1;
               r_d.tx_type      = r_q.os_run ? PSW_MSG_OSCOM : PSW_MSG_COM;
               r_d.tmr_on       = 1'b1;
               r_d.tmr          = r_q.os_run ? OS_LOAD : STD_LOAD;
               r_d.expired_once = 1'b1;
            end else if (expire) begin
               r_d.err = 1'b1;
               r_d.st  = LE_IDLE_STATE;
            end
            // A request message from the far side is ignored here
         end
         default: begin
            r_d = r_q;
            r_d.st = LE_IDLE_STATE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Synchronous reset clears every pulse and field before the state is set
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         r_q       <= '0;
         r_q.st    <= LE_IDLE_STATE;
      end else begin
         r_q <= r_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign link.le_msg_valid  = r_q.tx_valid;
   assign link.le_msg_type   = r_q.tx_type;
   assign link.le_msg_lchan  = r_q.lchan;
   assign link.le_msg_target = r_q.target;
   assign ind_ack            = r_q.ack;
   assign ind_reject         = r_q.rej;
   assign ind_cause          = r_q.cause;
   assign ind_error          = r_q.err;
   assign ind_an_req         = r_q.anreq;
   assign le_state           = state_code(r_q.st);
endmodule

// *** psw_an_end.sv ***
// Module: access-side switch-over machine answering exchange commands
`timescale 1ns/10ps
module psw_an_end (
   input  wire logic                       core_clk,
   input  wire logic                       rst_b,
   psw_link_if.an                          link,
   input  wire logic                       mgmt_accept,
   input  wire logic                       mgmt_refuse,
   input  wire logic [psw_pkg::CAUSE_W-1:0] mgmt_cause,
   output logic                            ind_com,
   output logic                            ind_os_com,
   output logic [psw_pkg::CH_W-1:0]        ind_lchan,
   output logic [psw_pkg::CH_W-1:0]        ind_target,
   output logic                            an_busy
);
   import psw_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      psw_an_state_t       st;
      logic                os_cmd;
      logic                com;
      logic                oscom;
      logic [CH_W-1:0]     lchan;
      logic [CH_W-1:0]     target;
      logic                tx_valid;
      psw_msg_t            tx_type;
      logic [CAUSE_W-1:0]  cause;
   } psw_an_reg_t;

   psw_an_reg_t r_q;
   psw_an_reg_t r_d;

   always_comb begin
      r_d          = r_q;
      r_d.com      = 1'b0;
      r_d.oscom    = 1'b0;
      r_d.tx_valid = 1'b0;
      case (r_q.st)
         AN_IDLE_STATE: begin
            if (link.le_msg_valid && (link.le_msg_type == PSW_MSG_COM ||
                                      link.le_msg_type == PSW_MSG_OSCOM)) begin
               // Indicate the command with its channels
               r_d.os_cmd = (link.le_msg_type == PSW_MSG_OSCOM);
               r_d.com    = (link.le_msg_type == PSW_MSG_COM);
               r_d.oscom  = (link.le_msg_type == PSW_MSG_OSCOM);
               r_d.lchan  = link.le_msg_lchan;
               r_d.target = link.le_msg_target;
               r_d.st     = AN_LE_INITIATED_STATE;
            end
            // Management answers with no command pending are dropped
         end
         AN_LE_INITIATED_STATE: begin
            if (mgmt_accept) begin
               r_d.tx_valid = 1'b1;
               r_d.tx_type  = PSW_MSG_ACK;
               r_d.st       = AN_IDLE_STATE;
            end else if (mgmt_refuse) begin
               // Occupied-target cause is swapped out for a forced command
               r_d.tx_valid = 1'b1;
               r_d.tx_type  = PSW_MSG_REJ;
               r_d.cause    = (r_q.os_cmd && mgmt_cause == CAUSE_TARGET_OCCUPIED) ?
                              CAUSE_NO_RESOURCE : mgmt_cause;
               r_d.st       = AN_IDLE_STATE;
            end
         end
         default: begin
            r_d.st = AN_IDLE_STATE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         r_q    <= '0;
         r_q.st <= AN_IDLE_STATE;
      end else begin
         r_q <= r_d;
      end
   end

   assign link.an_msg_valid = r_q.tx_valid;
   assign link.an_msg_type  = r_q.tx_type;
   assign link.an_msg_cause = r_q.cause;
   assign ind_com           = r_q.com;
   assign ind_os_com        = r_q.oscom;
   assign ind_lchan         = r_q.lchan;
   assign ind_target        = r_q.target;
   assign an_busy           = (r_q.st == AN_LE_INITIATED_STATE);
endmodule

// *** psw_link_monitor.sv ***
// Checker: concurrent checks on the link between the two switch-over ends
`timescale 1ns/10ps
module psw_link_monitor
   import psw_pkg::*;
#(
   parameter int STD_CYC = STD_RETRY_CYC,
   parameter int OS_CYC  = OS_RETRY_CYC
) (
   input wire logic               core_clk,
   input wire logic               rst_b,
   input wire logic               le_msg_valid,
   input wire psw_msg_t           le_msg_type,
   input wire logic [CH_W-1:0]    le_msg_lchan,
   input wire logic [CH_W-1:0]    le_msg_target,
   input wire logic               an_msg_valid,
   input wire psw_msg_t           an_msg_type,
   input wire logic [CAUSE_W-1:0] an_msg_cause
);
   // -------------------------------------------
   // Helper state: unanswered sends and spacing
   // -------------------------------------------
   localparam int GAP_LO = ((STD_CYC < OS_CYC) ? STD_CYC : OS_CYC) - 1;
   localparam int GAP_HI = ((STD_CYC > OS_CYC) ? STD_CYC : OS_CYC) + 2;
   logic [1:0]  sends_q;
   logic [15:0] gap_q;
   psw_msg_t    type_q;
   // Type is taken only from a fresh send, which the idle access end accepts
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sends_q <= 2'h0;
         gap_q   <= 16'h0;
         type_q  <= PSW_MSG_NONE;
      end else begin
         if (an_msg_valid) sends_q <= {1'b0, le_msg_valid};
         else if (le_msg_valid && sends_q != 2'h3) sends_q <= sends_q + 2'h1;
         if (le_msg_valid && sends_q == 2'h0) type_q <= le_msg_type;
         if (le_msg_valid) gap_q <= 16'h1;
         else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h1;
      end
   end
   // -------------------------------------------
   // Assertions
   // -------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence fresh_send; le_msg_valid && sends_q == 2'h0; endsequence
   sequence retry_send; le_msg_valid && sends_q == 2'h1; endsequence
   sequence quiet_two; !an_msg_valid ##1 !an_msg_valid; endsequence
   cmd_type_a: assert property (le_msg_valid |-> le_msg_type inside {PSW_MSG_COM, PSW_MSG_OSCOM})
      else $error("command type illegal");
   cmd_pulse_a: assert property (le_msg_valid |=> !le_msg_valid)
      else $error("command longer than one cycle");
   ans_type_a: assert property (an_msg_valid |-> an_msg_type inside {PSW_MSG_ACK, PSW_MSG_REJ})
      else $error("answer type illegal");
   ans_pulse_a: assert property (an_msg_valid |=> !an_msg_valid)
      else $error("answer longer than one cycle");
   ans_delay_a: assert property (fresh_send |-> quiet_two)
      else $error("answer before management decided");
   retry_gap_a: assert property (retry_send |-> gap_q >= GAP_LO && gap_q <= GAP_HI)
      else $error("resend spacing wrong");
   retry_type_a: assert property (retry_send |-> le_msg_type == type_q)
      else $error("resend type differs");
   forced_cause_a: assert property (an_msg_valid && an_msg_type == PSW_MSG_REJ &&
      type_q == PSW_MSG_OSCOM |-> an_msg_cause != CAUSE_TARGET_OCCUPIED)
      else $error("forbidden cause on forced command");
   chan_held_a: assert property (!le_msg_valid |-> $stable(le_msg_lchan) && $stable(le_msg_target))
      else $error("channel fields moved between sends");
endmodule

// *** testbench.sv ***
// Testbench: both switch-over ends joined across the link
`timescale 1ns/10ps
module testbench;
   import psw_pkg::*;
   logic               core_clk = 1'b0, rst_b = 1'b0;
   logic               mgmt_std_com = 1'b0, mgmt_os_com = 1'b0, mgmt_an_req = 1'b0;
   logic [GROUP_W-1:0] mgmt_group = 2'h0;
   logic [CH_W-1:0]    mgmt_lchan = 16'h0, mgmt_target = 16'h0, ind_lchan, ind_target;
   logic               mgmt_accept = 1'b0, mgmt_refuse = 1'b0;
   logic [CAUSE_W-1:0] mgmt_cause = 8'h0, ind_cause;
   logic               ind_ack, ind_reject, ind_error, ind_an_req, ind_com, ind_os_com, an_busy;
   logic [1:0]         le_state;
   psw_msg_t           exp_cmd, exp_ans;
   logic [CAUSE_W-1:0] exp_cause;
   int                 error_cnt = 0, compares = 0, sends, errs;
   psw_link_if psw_link_if_inst();
   psw_le_end #(.STD_CYC(20), .OS_CYC(24)) psw_le_end_inst (.core_clk(core_clk),
      .rst_b(rst_b), .link(psw_link_if_inst), .mgmt_std_com(mgmt_std_com),
      .mgmt_os_com(mgmt_os_com), .mgmt_group(mgmt_group), .mgmt_lchan(mgmt_lchan),
      .mgmt_target(mgmt_target), .mgmt_an_req(mgmt_an_req), .ind_ack(ind_ack),
      .ind_reject(ind_reject), .ind_cause(ind_cause), .ind_error(ind_error),
      .ind_an_req(ind_an_req), .le_state(le_state));
   psw_an_end psw_an_end_inst (.core_clk(core_clk), .rst_b(rst_b), .link(psw_link_if_inst),
      .mgmt_accept(mgmt_accept), .mgmt_refuse(mgmt_refuse), .mgmt_cause(mgmt_cause),
      .ind_com(ind_com), .ind_os_com(ind_os_com), .ind_lchan(ind_lchan),
      .ind_target(ind_target), .an_busy(an_busy));
   psw_link_monitor #(.STD_CYC(20), .OS_CYC(24)) psw_link_monitor_inst (.core_clk(core_clk),
      .rst_b(rst_b), .le_msg_valid(psw_link_if_inst.le_msg_valid),
      .le_msg_type(psw_link_if_inst.le_msg_type), .le_msg_lchan(psw_link_if_inst.le_msg_lchan),
      .le_msg_target(psw_link_if_inst.le_msg_target),
      .an_msg_valid(psw_link_if_inst.an_msg_valid),
      .an_msg_type(psw_link_if_inst.an_msg_type), .an_msg_cause(psw_link_if_inst.an_msg_cause));
   always #5 core_clk = ~core_clk;
   // -------------------------------------------
   // Tasks
   // -------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step();
      @(negedge core_clk);
   endtask
   // Command pulse; returns at the negedge where the link message shows
   task automatic command(input logic os, input logic [1:0] grp, input logic [15:0] lc);
      mgmt_std_com = !os;
      mgmt_os_com  = os;
      mgmt_group   = grp;
      mgmt_lchan   = lc;
      mgmt_target  = lc + 16'h0100;
      step();
      mgmt_std_com = 1'b0;
      mgmt_os_com  = 1'b0;
   endtask
   // Access management decision; returns where the answer message shows
   task automatic answer(input logic ok);
      mgmt_accept = ok;
      mgmt_refuse = !ok;
      mgmt_cause  = CAUSE_TARGET_OCCUPIED;
      step();
      mgmt_accept = 1'b0;
      mgmt_refuse = 1'b0;
   endtask
   task automatic summarize();
      $display("error_cnt=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Whole run is a few hundred cycles; far beyond that means a hang
   initial begin
      #20000;
      error_cnt++;
      summarize();
   end
   // -------------------------------------------
   // Tests
   // -------------------------------------------
   initial begin
      repeat (10) step();
      rst_b = 1'b1;
      step();
      // Standard and forced, each accepted and refused
      for (int k = 0; k < 4; k++) begin
         exp_cmd   = k[0] ? PSW_MSG_OSCOM : PSW_MSG_COM;
         exp_ans   = k[1] ? PSW_MSG_REJ : PSW_MSG_ACK;
         exp_cause = k[0] ? CAUSE_NO_RESOURCE : CAUSE_TARGET_OCCUPIED;
         command(k[0], 2'h2, 16'h0010 + 16'(k));
         check("msg_valid", psw_link_if_inst.le_msg_valid, 1);
         check("msg_type", psw_link_if_inst.le_msg_type, exp_cmd);
         check("msg_lchan", psw_link_if_inst.le_msg_lchan, 16'h0010 + k);
         check("msg_target", psw_link_if_inst.le_msg_target, 16'h0110 + k);
         check("le_state", le_state, 1);
         step();
         check("ind_com", ind_com, !k[0]);
         check("ind_os_com", ind_os_com, k[0]);
         check("ind_lchan", ind_lchan, 16'h0010 + k);
         check("ind_target", ind_target, 16'h0110 + k);
         check("an_busy", an_busy, 1);
         answer(!k[1]);
         check("ans_valid", psw_link_if_inst.an_msg_valid, 1);
         check("ans_type", psw_link_if_inst.an_msg_type, exp_ans);
         step();
         check("ind_ack", ind_ack, !k[1]);
         check("ind_reject", ind_reject, k[1]);
         if (k[1]) check("ind_cause", ind_cause, exp_cause);
         check("le_state", le_state, 0);
         check("an_busy", an_busy, 0);
      end
      // Forced command outside group two, stray primitives in idle
      for (int g = 0; g < 4; g++) begin
         if (g != 2) begin
            command(1'b1, g[1:0], 16'h0020);
            check("msg_valid", psw_link_if_inst.le_msg_valid, 0);
            step();
         end
      end
      mgmt_an_req = 1'b1;
      answer(1'b1);
      mgmt_an_req = 1'b0;
      check("ans_valid", psw_link_if_inst.an_msg_valid, 0);
      check("ind_an_req", ind_an_req, 0);
      check("le_state", le_state, 0);
      // Unanswered command: one resend, then error, then a late answer in idle
      for (int m = 0; m < 2; m++) begin
         exp_cmd = m[0] ? PSW_MSG_OSCOM : PSW_MSG_COM;
         command(m[0], 2'h2, 16'h0077);
         step();
         command(!m[0], 2'h2, 16'h0099);
         sends = 0;
         errs  = 0;
         repeat (90) begin
            step();
            if (psw_link_if_inst.le_msg_valid === 1'b1) begin
               sends++;
               check("resend type", psw_link_if_inst.le_msg_type, exp_cmd);
            end
            if (ind_error === 1'b1) errs++;
         end
         check("resends", sends, 1);
         check("errors", errs, 1);
         check("held lchan", psw_link_if_inst.le_msg_lchan, 16'h0077);
         check("le_state", le_state, 0);
         answer(!m[0]);
         step();
         check("idle ack", ind_ack, !m[0]);
         check("idle reject", ind_reject, m[0]);
         if (m[0]) check("idle cause", ind_cause, CAUSE_NO_RESOURCE);
         check("le_state", le_state, 0);
      end
      summarize();
   end
endmodule
